/* core/uem_pkg.sv */
// Constants, encodings and register layout of the endpoint mode and counter
// register set.
// Assumes one 40 MHz clock shared with the engine and the CPU port.
//
// Contract
// - Four mode bits choose token answers
// - Bit 4 set on ACK-completed transaction
// - Engine sets bit 5 on OUT token
// - Engine sets bit 6 on IN token
// - CPU mode register write clears setup flag
// - Setup flag held from data to ACK
// - Five-endpoint layout makes 0x42 non-control
// - Engine update locks endpoint 0 bits
// - CPU read releases endpoint 0 lock
// - Other mode registers never lock
// - Setup flag blocks endpoint 0 FIFO writes
// - Early SETUP may overwrite control payload
// - Stall bit stalls in acknowledge direction
// - Received count includes two CRC bytes
// - Data valid follows CRC result
// - Bit 7 is data toggle
// - Only endpoint 0 counter locks
// - Mode 0000 disables, 0001 accepts SETUP only
// - Odd acknowledge modes fall to NAK mode
// - Update point raises endpoint interrupt
package uem_pkg;

  localparam int NUM_EP = 5;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MODE_OFS [NUM_EP] = '{8'h12, 8'h14, 8'h16, 8'h42,
                                               8'h44};
  localparam logic [7:0] CNT_OFS [NUM_EP] = '{8'h11, 8'h13, 8'h15, 8'h41,
                                              8'h43};
  localparam logic [2:0] EP_B0_IDX = 3'h3;

  localparam int BIT_SETUP = 7;
  localparam int BIT_STALL = 7;
  localparam int BIT_IN = 6;
  localparam int BIT_OUT = 5;
  localparam int BIT_ACK = 4;
  localparam int BIT_TOGGLE = 7;
  localparam int BIT_VALID = 6;
  localparam int CFG_FIVE_EP = 0;
  localparam int CFG_BIG_EP = 1;

  localparam logic [7:0] FIFO_A0_SMALL = 8'hF8;
  localparam logic [7:0] FIFO_A0_BIG = 8'hB8;
  localparam logic [7:0] FIFO_B0_SMALL = 8'hE0;
  localparam logic [7:0] FIFO_B0_BIG = 8'hA8;
  localparam int FIFO_EP0_BYTES_LOG2 = 3;

  localparam int RX_WIDTH = 8;
  localparam int RX_DEPTH = 16;

  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;

  typedef enum logic [1:0] {
    PID_SETUP = 2'h0,
    PID_IN = 2'h1,
    PID_OUT = 2'h2
  } uem_pid_t;

  typedef enum logic [2:0] {
    RESP_IGNORE = 3'h0,
    RESP_ACK = 3'h1,
    RESP_NAK = 3'h2,
    RESP_STALL = 3'h3,
    RESP_TX_COUNT = 3'h4,
    RESP_TX_ZERO = 3'h5,
    RESP_CHECK = 3'h6
  } uem_resp_t;

endpackage : uem_pkg

/* core/uem_regs.sv */
// Endpoint mode and byte counter registers with the receive byte FIFO.
// Assumes the engine and CPU port run on mclk; engine inputs are pulses.
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Receive FIFO.
// ---------------------------------------------------------------------
module uem_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? wr_q + AW'(1) : wr_q;
    rd_d = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign out_data = mem_q[rd_q];
endmodule : uem_fifo

// ---------------------------------------------------------------------
// Register set.
// ---------------------------------------------------------------------
module uem_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [1:0] cfg_layout,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_q,
  input wire logic cpu_mem_we,
  input wire logic [7:0] cpu_mem_addr,
  input wire logic [7:0] cpu_mem_wdata,
  output logic mem_we_q,
  output logic [7:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  input wire logic sie_tok_valid,
  input wire logic [1:0] sie_tok_pid,
  input wire logic [2:0] sie_tok_ep,
  output logic sie_resp_valid_q,
  output logic [2:0] sie_resp_q,
  input wire logic sie_data_start,
  input wire logic sie_ack_start,
  input wire logic sie_update,
  input wire logic sie_upd_acked,
  input wire logic [5:0] sie_upd_bytes,
  input wire logic sie_upd_toggle,
  input wire logic sie_upd_crc_ok,
  input wire logic sie_upd_int,
  output logic [4:0] ep_int_q,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic ram_valid,
  output logic [7:0] ram_data,
  input wire logic ram_ready
);
  logic [7:0] mode_q [uem_pkg::NUM_EP];
  logic [7:0] mode_d [uem_pkg::NUM_EP];
  logic [7:0] cnt_q [uem_pkg::NUM_EP];
  logic [7:0] cnt_d [uem_pkg::NUM_EP];
  logic [1:0] mlock_q, mlock_d, clock_q, clock_d, hold_q, hold_d;
  logic [2:0] ep_q, ep_d;
  logic [1:0] pid_q, pid_d;
  logic resp_valid_d;
  logic [2:0] resp_d;
  logic [4:0] int_d;
  logic [7:0] rdata_d;
  logic five_ep;
  logic [4:0] ep0_mask;
  logic blk_we;

  // Answer of one mode to one token.
  function automatic logic [2:0] resp_f(input logic [3:0] mode,
                                        input logic [1:0] pid,
                                        input logic stall);
    logic [2:0] s, i, o;
    s = uem_pkg::RESP_IGNORE;
    i = uem_pkg::RESP_IGNORE;
    o = uem_pkg::RESP_IGNORE;
    case (mode)
      4'h0: begin end
      4'h1: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_NAK;
        o = uem_pkg::RESP_NAK; end
      4'h2: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_STALL;
        o = uem_pkg::RESP_CHECK; end
      4'h3: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_STALL;
        o = uem_pkg::RESP_STALL; end
      4'h4: s = uem_pkg::RESP_ACK;
      4'h5: o = uem_pkg::RESP_ACK;
      4'h6: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_TX_ZERO;
        o = uem_pkg::RESP_STALL; end
      4'h7: i = uem_pkg::RESP_TX_COUNT;
      4'h8: o = uem_pkg::RESP_NAK;
      4'h9: o = stall ? uem_pkg::RESP_STALL : uem_pkg::RESP_ACK;
      4'hA: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_TX_ZERO;
        o = uem_pkg::RESP_NAK; end
      4'hB: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_TX_ZERO;
        o = uem_pkg::RESP_ACK; end
      4'hC: i = uem_pkg::RESP_NAK;
      4'hD: i = stall ? uem_pkg::RESP_STALL : uem_pkg::RESP_TX_COUNT;
      4'hE: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_NAK;
        o = uem_pkg::RESP_CHECK; end
      4'hF: begin s = uem_pkg::RESP_ACK; i = uem_pkg::RESP_TX_COUNT;
        o = uem_pkg::RESP_CHECK; end
      default: begin end
    endcase
    case (pid)
      uem_pkg::PID_SETUP: resp_f = s;
      uem_pkg::PID_IN: resp_f = i;
      uem_pkg::PID_OUT: resp_f = o;
      default: resp_f = uem_pkg::RESP_IGNORE;
    endcase
  endfunction : resp_f

  // Device index of an endpoint 0 register: 0 for address A, 1 for B.
  function automatic logic dev_f(input logic [2:0] idx);
    dev_f = idx == uem_pkg::EP_B0_IDX;
  endfunction : dev_f

  // True when a memory byte lies in an endpoint 0 FIFO held by a setup.
  function automatic logic fifo_blk_f(input logic [7:0] a,
                                      input logic [1:0] cfg,
                                      input logic [1:0] hold);
    logic [7:0] base_a, base_b;
    base_a = cfg[uem_pkg::CFG_BIG_EP] ? uem_pkg::FIFO_A0_BIG
                                      : uem_pkg::FIFO_A0_SMALL;
    base_b = cfg[uem_pkg::CFG_BIG_EP] ? uem_pkg::FIFO_B0_BIG
                                      : uem_pkg::FIFO_B0_SMALL;
    fifo_blk_f = (hold[0] && a[7:uem_pkg::FIFO_EP0_BYTES_LOG2] ==
                  base_a[7:uem_pkg::FIFO_EP0_BYTES_LOG2]) ||
                 (hold[1] && !cfg[uem_pkg::CFG_FIVE_EP] &&
                  a[7:uem_pkg::FIFO_EP0_BYTES_LOG2] ==
                  base_b[7:uem_pkg::FIFO_EP0_BYTES_LOG2]);
  endfunction : fifo_blk_f

  always_comb begin
    five_ep = cfg_layout[uem_pkg::CFG_FIVE_EP];
    ep0_mask = {1'b0, !five_ep, 3'b001};
    for (int k = 0; k < uem_pkg::NUM_EP; k++) begin
      mode_d[k] = mode_q[k];
      cnt_d[k] = cnt_q[k];
    end
    mlock_d = mlock_q;
    clock_d = clock_q;
    hold_d = hold_q;
    ep_d = ep_q;
    pid_d = pid_q;
    resp_valid_d = 1'b0;
    resp_d = sie_resp_q;
    int_d = '0;
    rdata_d = '0;
    // CPU side: reads release locks, writes respect them.
    for (int k = 0; k < uem_pkg::NUM_EP; k++) begin
      if (io_rd && io_addr == uem_pkg::MODE_OFS[k]) begin
        rdata_d = mode_q[k];
        if (ep0_mask[k]) begin
          mlock_d[dev_f(3'(k))] = 1'b0;
        end
      end
      if (io_rd && io_addr == uem_pkg::CNT_OFS[k]) begin
        rdata_d = cnt_q[k];
        if (ep0_mask[k]) begin
          clock_d[dev_f(3'(k))] = 1'b0;
        end
      end
      if (io_wr && io_addr == uem_pkg::MODE_OFS[k]) begin
        if (!ep0_mask[k]) begin
          mode_d[k] = io_wdata;
        end else begin
          if (!hold_q[dev_f(3'(k))]) begin
            mode_d[k][uem_pkg::BIT_SETUP] = 1'b0;
          end
          if (!mlock_q[dev_f(3'(k))]) begin
            mode_d[k][6:0] = io_wdata[6:0];
          end
        end
      end
      if (io_wr && io_addr == uem_pkg::CNT_OFS[k]) begin
        if (!ep0_mask[k] || !clock_q[dev_f(3'(k))]) begin
          cnt_d[k] = io_wdata;
        end
      end
    end
    // Token phase: answer from the current mode.
    if (sie_tok_valid && sie_tok_ep < 3'(uem_pkg::NUM_EP)) begin
      ep_d = sie_tok_ep;
      pid_d = sie_tok_pid;
      resp_valid_d = 1'b1;
      resp_d = resp_f(mode_q[sie_tok_ep][3:0], sie_tok_pid,
                      !ep0_mask[sie_tok_ep] &&
                      mode_q[sie_tok_ep][uem_pkg::BIT_STALL]);
    end
    // Setup data start forces the setup flag until the ACK begins.
    if (sie_data_start && pid_q == uem_pkg::PID_SETUP && ep0_mask[ep_q]) begin
      mode_d[ep_q][uem_pkg::BIT_SETUP] = 1'b1;
      hold_d[dev_f(ep_q)] = 1'b1;
    end
    if (sie_ack_start) begin
      hold_d = '0;
    end
    // Update point: engine writes win over same-cycle CPU activity.
    if (sie_update) begin
      if (sie_upd_acked) begin
        mode_d[ep_q][uem_pkg::BIT_ACK] = 1'b1;
        if (mode_q[ep_q][3] && mode_q[ep_q][0]) begin
          mode_d[ep_q][3:0] = mode_q[ep_q][3:0] - 4'h1;
        end
      end
      if (ep0_mask[ep_q]) begin
        mode_d[ep_q][uem_pkg::BIT_OUT] = pid_q == uem_pkg::PID_OUT;
        mode_d[ep_q][uem_pkg::BIT_IN] = pid_q == uem_pkg::PID_IN;
        if (pid_q == uem_pkg::PID_SETUP &&
            mode_q[ep_q][3:0] != uem_pkg::MODE_DISABLE) begin
          mode_d[ep_q][3:0] = uem_pkg::MODE_NAK_INOUT;
        end
        mlock_d[dev_f(ep_q)] = 1'b1;
      end
      if (pid_q != uem_pkg::PID_IN) begin
        // Payload may replace unread control data.
        cnt_d[ep_q][5:0] = sie_upd_bytes;
        cnt_d[ep_q][uem_pkg::BIT_VALID] = sie_upd_crc_ok;
        cnt_d[ep_q][uem_pkg::BIT_TOGGLE] = sie_upd_toggle;
        if (ep0_mask[ep_q]) begin
          clock_d[dev_f(ep_q)] = 1'b1;
        end
      end
      int_d[ep_q] = sie_upd_int;
    end
    blk_we = cpu_mem_we &&
             !fifo_blk_f(cpu_mem_addr, cfg_layout,
                         {mode_q[uem_pkg::EP_B0_IDX][uem_pkg::BIT_SETUP],
                          mode_q[0][uem_pkg::BIT_SETUP]});
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int k = 0; k < uem_pkg::NUM_EP; k++) begin
        mode_q[k] <= uem_pkg::REG_RESET;
        cnt_q[k] <= uem_pkg::REG_RESET;
      end
      mlock_q <= '0;
      clock_q <= '0;
      hold_q <= '0;
      ep_q <= '0;
      pid_q <= uem_pkg::PID_SETUP;
      sie_resp_valid_q <= 1'b0;
      sie_resp_q <= uem_pkg::RESP_IGNORE;
      ep_int_q <= '0;
      io_rdata_q <= '0;
      mem_we_q <= 1'b0;
      mem_addr_q <= '0;
      mem_wdata_q <= '0;
    end else begin
      for (int k = 0; k < uem_pkg::NUM_EP; k++) begin
        mode_q[k] <= mode_d[k];
        cnt_q[k] <= cnt_d[k];
      end
      mlock_q <= mlock_d;
      clock_q <= clock_d;
      hold_q <= hold_d;
      ep_q <= ep_d;
      pid_q <= pid_d;
      sie_resp_valid_q <= resp_valid_d;
      sie_resp_q <= resp_d;
      ep_int_q <= int_d;
      io_rdata_q <= rdata_d;
      mem_we_q <= blk_we;
      mem_addr_q <= cpu_mem_addr;
      mem_wdata_q <= cpu_mem_wdata;
    end
  end

  uem_fifo #(
    .WIDTH(uem_pkg::RX_WIDTH),
    .DEPTH(uem_pkg::RX_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(ram_valid),
    .out_data(ram_data),
    .out_ready(ram_ready)
  );
endmodule : uem_regs

/* test/uem_assertions.sv */
// Checker for the endpoint mode and counter register set.
// Assumes it is bound to uem_regs and sees only its ports.
`timescale 1ns/1ps
// ----
// Checker.
// ----
module uem_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata_q,
  input wire logic cpu_mem_we,
  input wire logic [7:0] cpu_mem_addr,
  input wire logic mem_we_q,
  input wire logic [7:0] mem_addr_q,
  input wire logic sie_tok_valid,
  input wire logic [2:0] sie_tok_ep,
  input wire logic sie_resp_valid_q,
  input wire logic sie_update,
  input wire logic sie_upd_int,
  input wire logic [4:0] ep_int_q,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic ram_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rdata_idle_a: assert property (
    !$past(io_rd) |-> io_rdata_q == 8'h00) else $error("stray read data");
  resp_follow_a: assert property (
    sie_tok_valid && sie_tok_ep < 3'h5 |=> sie_resp_valid_q)
    else $error("token not answered");
  resp_cause_a: assert property (
    sie_resp_valid_q |-> $past(sie_tok_valid) && $past(sie_tok_ep) < 3'h5)
    else $error("answer without token");
  int_raise_a: assert property (
    sie_update && sie_upd_int |=> $onehot(ep_int_q) ##1 ep_int_q == 5'h00)
    else $error("interrupt pulse wrong");
  int_cause_a: assert property (
    ep_int_q != 5'h00 |-> $past(sie_update) && $past(sie_upd_int))
    else $error("interrupt without update");
  mem_guard_a: assert property (
    mem_we_q |-> $past(cpu_mem_we) && mem_addr_q == $past(cpu_mem_addr))
    else $error("memory write not requested");
  mem_pass_a: assert property (
    cpu_mem_we && cpu_mem_addr < 8'hA8 |=> mem_we_q)
    else $error("plain memory write dropped");
  fifo_take_a: assert property (
    rx_valid && rx_ready |=> ram_valid) else $error("fifo lost a word");
endmodule : uem_assertions

bind uem_regs uem_assertions chk_u (.mclk(mclk), .rst_n(rst_n),
  .io_rd(io_rd), .io_rdata_q(io_rdata_q), .cpu_mem_we(cpu_mem_we),
  .cpu_mem_addr(cpu_mem_addr), .mem_we_q(mem_we_q), .mem_addr_q(mem_addr_q),
  .sie_tok_valid(sie_tok_valid), .sie_tok_ep(sie_tok_ep),
  .sie_resp_valid_q(sie_resp_valid_q), .sie_update(sie_update),
  .sie_upd_int(sie_upd_int), .ep_int_q(ep_int_q), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .ram_valid(ram_valid));

/* test/uem_host_model.sv */
// Engine-side model playing token, data, handshake and update points.
// Assumes the bench pulses go and holds the transfer fields meanwhile.
`timescale 1ns/1ps
// ----
// Host model.
// ----
module uem_host_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic [1:0] pid,
  input wire logic [2:0] ep,
  input wire logic [5:0] nb,
  input wire logic tog,
  input wire logic crc,
  input wire logic [2:0] sie_resp_q,
  output logic sie_tok_valid,
  output logic [1:0] sie_tok_pid,
  output logic [2:0] sie_tok_ep,
  output logic sie_data_start,
  output logic sie_ack_start,
  output logic sie_update,
  output logic sie_upd_acked,
  output logic [5:0] sie_upd_bytes,
  output logic sie_upd_toggle,
  output logic sie_upd_crc_ok,
  output logic sie_upd_int,
  output logic done
);
  int c = 0;
  logic ok = 1'b0;
  logic [7:0] ph = 8'h00;
  assign done = c == 7;
  always @(posedge mclk) begin
    ph <= ph + 8'h01;
    c <= go ? 1 : (c == 0 || c == 7) ? 0 : c + 1;
    if (c == 2) ok <= sie_resp_q inside {3'h1, 3'h4, 3'h5} && crc;
    sie_tok_valid <= go;
    sie_tok_pid <= go ? pid : ph[1:0];
    sie_tok_ep <= go ? ep : ph[4:2];
    sie_data_start <= c == 2 && pid != 2'h1 && ep < 3'h5;
    sie_ack_start <= c == 4;
    sie_update <= c == 5 && ep < 3'h5;
    sie_upd_acked <= c == 5 ? ok : ph[0];
    sie_upd_bytes <= c == 5 ? nb + 6'h02 : ph[5:0];
    sie_upd_toggle <= c == 5 ? tog : ph[1];
    sie_upd_crc_ok <= c == 5 ? crc : ph[2];
    sie_upd_int <= c == 5 || ph[3];
  end
endmodule : uem_host_model

/* test/uem_regs_bench.sv */
// Self-checking bench for the endpoint mode and counter register set.
// Assumes the checker is bound and the host model drives the engine side.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  n_mismatch++; $display("Error at %0t: got %h want %h", $time, a, e); end end
// ----
// Bench.
// ----
module uem_regs_bench;
  logic mclk = 0, rst_n = 0, io_wr = 0, io_rd = 0, cpu_mem_we = 0, go = 0;
  logic tog = 0, crc = 0, rx_valid = 0, ram_ready = 0, rd_d = 0;
  logic [1:0] cfg_layout = 2'h0, pid = 2'h0, sie_tok_pid;
  logic [2:0] ep = 3'h0, sie_resp_q, sie_tok_ep, pq[$];
  logic [5:0] nb = 6'h00, sie_upd_bytes;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, cpu_mem_addr = 8'h00;
  logic [7:0] cpu_mem_wdata = 8'h00, rx_data = 8'h00, io_rdata_q;
  logic [7:0] mem_addr_q, mem_wdata_q, ram_data, rq[$], fq[$];
  logic [15:0] mw, mq[$];
  logic [4:0] ep_int_q;
  logic mem_we_q, sie_resp_valid_q, sie_tok_valid, sie_data_start, done;
  logic sie_ack_start, sie_update, sie_upd_acked, sie_upd_toggle, rx_ready;
  logic sie_upd_crc_ok, sie_upd_int, ram_valid;
  logic [31:0] lf = 32'hCF20;
  int n_mismatch = 0, samples_checked = 0, k = 0;
  always #12.5 mclk = ~mclk;
  uem_regs dut_u (.mclk, .rst_n, .cfg_layout, .io_wr, .io_rd, .io_addr,
    .io_wdata, .io_rdata_q, .cpu_mem_we, .cpu_mem_addr, .cpu_mem_wdata,
    .mem_we_q, .mem_addr_q, .mem_wdata_q, .sie_tok_valid, .sie_tok_pid,
    .sie_tok_ep, .sie_resp_valid_q, .sie_resp_q, .sie_data_start,
    .sie_ack_start, .sie_update, .sie_upd_acked, .sie_upd_bytes,
    .sie_upd_toggle, .sie_upd_crc_ok, .sie_upd_int, .ep_int_q, .rx_valid,
    .rx_data, .rx_ready, .ram_valid, .ram_data, .ram_ready);
  uem_host_model host_u (.mclk, .go, .pid, .ep, .nb, .tog, .crc, .sie_resp_q,
    .sie_tok_valid, .sie_tok_pid, .sie_tok_ep, .sie_data_start,
    .sie_ack_start, .sie_update, .sie_upd_acked, .sie_upd_bytes,
    .sie_upd_toggle, .sie_upd_crc_ok, .sie_upd_int, .done);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) rq.push_back(d);
    @(posedge mclk);
    io_wr <= w;
    io_rd <= !w;
    io_addr <= a;
    io_wdata <= d;
    @(posedge mclk);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask : acc
  task automatic mem(input logic [7:0] a, input logic pass);
    lf = nx(lf);
    if (pass) mq.push_back({a, lf[7:0]});
    @(posedge mclk);
    cpu_mem_we <= 1'b1;
    cpu_mem_addr <= a;
    cpu_mem_wdata <= lf[7:0];
    @(posedge mclk);
    cpu_mem_we <= 1'b0;
  endtask : mem
  task automatic txn(input logic [1:0] p, input logic [2:0] e,
                     input logic [7:0] info, input logic [2:0] r);
    if (e < 3'h5) pq.push_back(r);
    @(posedge mclk);
    go <= 1'b1;
    pid <= p;
    ep <= e;
    {tog, crc, nb} <= info;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 20 && !done; i++) @(posedge mclk);
    @(posedge mclk);
  endtask : txn
  task automatic close_out();
    $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  always @(posedge mclk) rd_d <= io_rd;
  always @(negedge mclk) begin
    if (rd_d)
      `CHK(io_rdata_q, rq.size() ? rq.pop_front() : 8'hXX)
    if (sie_resp_valid_q)
      `CHK(sie_resp_q, pq.size() ? pq.pop_front() : 3'hX)
    if (mem_we_q) begin
      mw = mq.size() ? mq.pop_front() : 16'hX;
      `CHK({mem_addr_q, mem_wdata_q}, mw)
    end
    if (ram_valid && ram_ready)
      `CHK(ram_data, fq.size() ? fq.pop_front() : 8'hXX)
  end
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      acc(0, uem_pkg::MODE_OFS[i], uem_pkg::REG_RESET);
      acc(0, uem_pkg::CNT_OFS[i], uem_pkg::REG_RESET);
    end
    acc(0, 8'h20, 8'h00);
    for (int i = 1; i < 3; i++) begin
      lf = nx(lf);
      acc(1, uem_pkg::MODE_OFS[i], lf[7:0] & 8'h1F);
      acc(0, uem_pkg::MODE_OFS[i], lf[7:0] & 8'h1F);
    end
    $display("reset test done");
    acc(1, 8'h12, 8'h01);
    txn(2'h0, 3'h0, 8'h48, 3'h1);
    mem(8'hF8, 0);
    mem(8'h30, 1);
    acc(1, 8'h11, 8'h00);
    acc(0, 8'h12, 8'h91);
    acc(1, 8'h12, 8'h8F);
    acc(0, 8'h12, 8'h0F);
    acc(0, 8'h11, 8'h4A);
    mem(8'hF8, 1);
    acc(1, 8'h11, 8'h05);
    acc(0, 8'h11, 8'h05);
    acc(1, 8'h12, 8'h0B);
    $display("setup test done");
    txn(2'h1, 3'h0, 8'h40, 3'h5);
    acc(1, 8'h12, 8'h0F);
    acc(0, 8'h12, 8'h5A);
    acc(0, 8'h11, 8'h05);
    acc(1, 8'h12, 8'h0B);
    txn(2'h2, 3'h0, 8'h80, 3'h1);
    acc(0, 8'h12, 8'h2B);
    acc(0, 8'h11, 8'h82);
    $display("in out test done");
    cfg_layout <= 2'h1;
    for (int i = 1; i < 4; i++) begin
      acc(1, uem_pkg::MODE_OFS[i], i > 1 ? 8'h8D : 8'h00);
      txn(2'h1, 3'(i), 8'h00, i > 1 ? 3'h3 : 3'h0);
    end
    txn(2'h1, 3'h5, 8'h00, 3'h0);
    $display("token test done");
    for (int i = 0; i < 21; i++) begin
      @(posedge mclk);
      if (rx_valid && rx_ready) begin
        fq.push_back(rx_data);
        k++;
      end
      if (!rx_valid || rx_ready) begin
        lf = nx(lf);
        rx_valid <= k < 16;
        rx_data <= lf[7:0];
      end
    end
    `CHK(k, 16)
    `CHK(rx_ready, 1'b0)
    repeat (50) @(posedge mclk) ram_ready <= ~ram_ready;
    $display("fifo test done");
    `CHK(rq.size() + pq.size() + mq.size() + fq.size(), 0)
    close_out();
  end
endmodule : uem_regs_bench
